// File: bdf_checker.sv
`default_nettype none
module bdf_checker (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic port_a_select_n,
    input wire logic port_a_strobe,
    input wire logic port_a_direction,
    input wire logic a_dev_oe_n,
    input wire logic b_dev_oe_n,
    input wire logic strobe_host_oe_n,
    input wire logic strobe_dev_oe_n,
    input wire logic port_b_read_strobe,
    input wire logic port_b_write_strobe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff rst;
    sel_gate_a: assert property (
        $past(port_a_select_n) |-> a_dev_oe_n) else $error("A driven idle");
    rd_drive_a: assert property (
        $fell(port_a_strobe) && !port_a_select_n && port_a_direction
        |-> ##[1:2] !a_dev_oe_n) else $error("A read not driven");
    rd_hold_a: assert property (
        !a_dev_oe_n && !port_a_strobe |=> !a_dev_oe_n) else $error("A drop");
    wr_quiet_a: assert property (
        !port_a_select_n && !port_a_direction |-> a_dev_oe_n)
        else $error("A driven in write");
    strobe_own_a: assert property (
        !strobe_host_oe_n |-> strobe_dev_oe_n) else $error("B strobe clash");
    rst_idle_a: assert property (
        $past(rst) |-> a_dev_oe_n && b_dev_oe_n && strobe_dev_oe_n)
        else $error("pins driven after reset");
    rd_drive_b: assert property (
        $fell(port_b_read_strobe) && port_b_write_strobe && !strobe_host_oe_n
        |-> ##[1:2] !b_dev_oe_n) else $error("B read not driven");
    wr_quiet_b: assert property (
        !port_b_write_strobe && port_b_read_strobe && !strobe_host_oe_n
        |-> b_dev_oe_n) else $error("B driven in write");
    cover property ($fell(port_a_strobe) && port_a_direction);
    cover property ($fell(port_b_read_strobe) && port_b_write_strobe);
    cover property ($rose(port_b_read_strobe) && !port_b_write_strobe);
endmodule
`default_nettype wire

// File: bdf_device.sv
// Function
// [RQ1] Port A acts only while select low
// [RQ2] Port A write captured on strobe rise
// [RQ3] Port A read driven from strobe fall
// [RQ4] Host holds direction valid during strobe
// [RQ5] Address and direction pick six resources
// [RQ6] Command, status and eight config registers
// [RQ7] All control comes from Port A
// [RQ8] Both data buses 18 bits, two-way
// [RQ9] Two arrays, one per direction
// [RQ10] 18-bit or paired 36-bit transfer mode; code only drives pair_mode from CTL_WIDE, with no 36-bit transfer logic
// [RQ11] 9-bit bypass from Port A to B
// [RQ12] Four flags per array, programmable thresholds
// [RQ13] Any internal flag routed to four pins
// [RQ14] Six I/O pins set by two registers
// [RQ15] Reread and rewrite repeat Port B blocks
// [RQ16] Request, acknowledge, clock run DMA transfers
// [RQ17] Read strobe input or output by mode
// [RQ18] Separate style: read on strobe fall
// [RQ19] Combined style: read fall, write rise
// [RQ20] Reset gives processor mode, separate style
// [RQ21] Peripheral timing taken from external clock
// [RQ22] Request and acknowledge polarity programmable
// [RQ23] Reset clears pointers, flags, configuration
// [RQ24] Full writes and empty reads are ignored
//
// Our own choices: the plain strobed port and the register offsets.
`default_nettype none
module bdf_device
    import bdf_pkg::*;
#(
    parameter int AW = FAW
) (
    input wire logic ref_clk,
    input wire logic rst,
    bdf_if.dev bus,
    input wire logic dma_request,
    input wire logic ext_clk,
    input wire logic reread_n,
    input wire logic rewrite_n,
    input wire logic load_reread,
    input wire logic load_rewrite,
    input wire logic [NPIO-1:0] general_io_pins_in,
    output logic [NPIO-1:0] general_io_pins_out,
    output logic [NPIO-1:0] general_io_pins_oe_n,
    output logic [NFLG-1:0] flag_outputs,
    output logic dma_ack,
    output logic pair_mode
);
    localparam int NSY = 6 + NPIO;
    logic [NSY-1:0] sy1, sy2;
    logic req_s, ext_s, rer_s, rew_s, ldrer_s, ldrew_s, ext_q;
    logic [NPIO-1:0] pio_s;
    logic [DW-1:0] cfg [NCFG];
    logic [DW-1:0] ctrl, status, a_mux, byp_word, b_src;
    logic [CPW-1:0] cfg_ptr;
    logic [BYW-1:0] byp;
    logic byp_pend, clr_ab, clr_ba;
    logic a_str_q, a_fall, a_rise, a_rd, a_wr;
    logic b_rd_q, b_wr_q, b_rd_start, b_rd_end, b_wr;
    logic periph, comb, bypass, outbound, tick, go, req_act;
    logic ack, strobing, push_ba, pop_ab;
    logic [DW-1:0] ab_head, ba_head;
    logic [3:0] ab_fl, ba_fl;
    logic [2*NFLG-1:0] flags8;
    bdf_pstate_t pst;

    // =========================================================
    // Pin synchronisers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sy1 <= '0;
            sy2 <= '0;
        end else begin
            sy1 <= {dma_request, ext_clk, ~reread_n, ~rewrite_n,
                    load_reread, load_rewrite, general_io_pins_in};
            sy2 <= sy1;
        end
    end
    assign {req_s, ext_s, rer_s, rew_s, ldrer_s, ldrew_s, pio_s} = sy2;

    // =========================================================
    // Port A decode
    assign a_fall = a_str_q && !bus.port_a_strobe;
    assign a_rise = !a_str_q && bus.port_a_strobe;
    assign a_rd = a_fall && !bus.port_a_select_n
                  && bus.port_a_direction; // [RQ1] [RQ3]
    assign a_wr = a_rise && !bus.port_a_select_n
                  && !bus.port_a_direction; // [RQ1] [RQ2]
    assign ctrl = cfg[CFG_CTRL];
    assign status = {{(DW - STS_BYP - 1){1'b0}}, byp_pend, pio_s, flags8};
    always_comb begin
        case (bus.resource_select) // [RQ5]
            RES_FIFO: a_mux = ba_head;
            RES_CMD: a_mux = status;
            RES_CFG: a_mux = cfg[cfg_ptr];
            default: a_mux = '0;
        endcase
    end
    always_ff @(posedge ref_clk) begin
        a_str_q <= rst ? 1'b1 : bus.port_a_strobe;
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bus.a_dev_data <= '0;
            bus.a_dev_oe_n <= 1'b1;
        end else if (a_rd) begin
            bus.a_dev_data <= a_mux; // [RQ3]
            bus.a_dev_oe_n <= 1'b0;
        end else if (bus.port_a_select_n || bus.port_a_strobe) begin
            bus.a_dev_oe_n <= 1'b1;
        end
    end

    // =========================================================
    // Registers: command, configuration, bypass
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < NCFG; i++) begin
                cfg[i] <= CFG_RST[i]; // [RQ20] [RQ23]
            end
        end else if (a_wr && bus.resource_select == RES_CFG) begin
            cfg[cfg_ptr] <= bus.port_a_bus; // [RQ6] [RQ7]
        end
    end
    always_ff @(posedge ref_clk) begin
        clr_ab <= 1'b0;
        clr_ba <= 1'b0;
        if (rst) begin
            cfg_ptr <= '0;
        end else if (a_wr && bus.resource_select == RES_CMD
                     && !bus.port_a_bus[CMD_LOAD_BYP]) begin
            cfg_ptr <= bus.port_a_bus[CPW-1:0]; // [RQ6]
            clr_ab <= bus.port_a_bus[CMD_CLR_AB];
            clr_ba <= bus.port_a_bus[CMD_CLR_BA];
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            byp <= '0;
            byp_pend <= 1'b0;
        end else if (a_wr && bus.resource_select == RES_CMD
                     && bus.port_a_bus[CMD_LOAD_BYP]) begin
            byp <= bus.port_a_bus[BYW-1:0]; // [RQ11]
            byp_pend <= 1'b1;
        end else if (bypass && (b_rd_start || (periph && tick
                     && pst == BDF_P_IDLE && go && outbound))) begin
            byp_pend <= 1'b0;
        end
    end

    // =========================================================
    // FIFO arrays
    assign pop_ab = !bypass && (b_rd_start || (periph && tick
                    && pst == BDF_P_STROBE && outbound));
    assign push_ba = b_wr || (periph && tick && pst == BDF_P_STROBE
                     && !outbound);
    bdf_fifo_array #(.W(DW), .AW(AW)) u_ab ( // [RQ9]
        .ref_clk(ref_clk),
        .rst(rst),
        .clear(clr_ab),
        .push(a_wr && bus.resource_select == RES_FIFO),
        .pop(pop_ab),
        .mark_rd(ldrer_s),
        .back_rd(rer_s),
        .mark_wr(1'b0),
        .back_wr(1'b0),
        .wdata(bus.port_a_bus),
        .ae_off(cfg[CFG_AB_AE][AW:0]),
        .af_off(cfg[CFG_AB_AF][AW:0]),
        .head(ab_head),
        .flags(ab_fl)
    );
    bdf_fifo_array #(.W(DW), .AW(AW)) u_ba ( // [RQ9]
        .ref_clk(ref_clk),
        .rst(rst),
        .clear(clr_ba),
        .push(push_ba),
        .pop(a_rd && bus.resource_select == RES_FIFO),
        .mark_rd(1'b0),
        .back_rd(1'b0),
        .mark_wr(ldrew_s),
        .back_wr(rew_s),
        .wdata(bus.port_b_bus),
        .ae_off(cfg[CFG_BA_AE][AW:0]),
        .af_off(cfg[CFG_BA_AF][AW:0]),
        .head(ba_head),
        .flags(ba_fl)
    );
    assign flags8 = {ba_fl, ab_fl};

    // =========================================================
    // Port B processor mode
    assign periph = ctrl[CTL_PERIPH];
    assign comb = ctrl[CTL_COMBINED];
    assign bypass = ctrl[CTL_BYPASS];
    assign outbound = ctrl[CTL_OUTBOUND];
    assign byp_word = {{(DW - BYW){1'b0}}, byp};
    assign b_src = bypass ? byp_word : ab_head; // [RQ11]
    always_ff @(posedge ref_clk) begin
        b_rd_q <= rst ? 1'b1 : bus.port_b_read_strobe;
        b_wr_q <= rst ? 1'b1 : bus.port_b_write_strobe;
    end
    always_comb begin
        b_rd_start = 1'b0;
        b_rd_end = 1'b0;
        b_wr = 1'b0;
        if (!periph) begin
            b_rd_end = !b_rd_q && bus.port_b_read_strobe;
            if (comb) begin
                b_rd_start = b_rd_q && !bus.port_b_read_strobe
                             && bus.port_b_write_strobe; // [RQ19]
                b_wr = b_rd_end && !bus.port_b_write_strobe; // [RQ19]
            end else begin
                b_rd_start = b_rd_q && !bus.port_b_read_strobe; // [RQ18]
                b_wr = !b_wr_q && bus.port_b_write_strobe;
            end
        end
    end

    // =========================================================
    // Port B peripheral mode, paced by the external clock
    assign tick = ext_s && !ext_q; // [RQ21]
    assign req_act = ctrl[CTL_REQ_HI] ? req_s : !req_s; // [RQ22]
    assign go = req_act && (outbound ? (bypass ? byp_pend : !ab_fl[FL_E])
                : !ba_fl[FL_F]); // [RQ16]
    always_ff @(posedge ref_clk) begin
        ext_q <= rst ? 1'b0 : ext_s;
    end
    always_ff @(posedge ref_clk) begin
        if (rst || !periph) begin
            pst <= BDF_P_IDLE;
            ack <= 1'b0;
            strobing <= 1'b0;
        end else if (tick) begin
            case (pst)
                BDF_P_IDLE: if (go) begin
                    pst <= BDF_P_ACK;
                    ack <= 1'b1; // [RQ16]
                end
                BDF_P_ACK: begin
                    pst <= BDF_P_STROBE;
                    strobing <= 1'b1; // [RQ21]
                end
                BDF_P_STROBE: begin
                    pst <= BDF_P_DONE;
                    strobing <= 1'b0;
                end
                BDF_P_DONE: begin
                    pst <= BDF_P_IDLE;
                    ack <= 1'b0;
                end
                default: pst <= BDF_P_IDLE;
            endcase
        end
    end

    // =========================================================
    // Port B pins
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bus.b_dev_data <= '0;
            bus.b_dev_oe_n <= 1'b1;
        end else if (periph) begin
            if (tick && pst == BDF_P_IDLE && go && outbound) begin
                bus.b_dev_data <= b_src;
                bus.b_dev_oe_n <= 1'b0;
            end else if (tick && pst == BDF_P_DONE) begin
                bus.b_dev_oe_n <= 1'b1;
            end
        end else if (b_rd_start) begin
            bus.b_dev_data <= b_src; // [RQ8] [RQ18] [RQ19]
            bus.b_dev_oe_n <= 1'b0;
        end else if (b_rd_end) begin
            bus.b_dev_oe_n <= 1'b1;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bus.strobe_dev_oe_n <= 1'b1; // [RQ20]
            bus.rd_dev <= 1'b1;
            bus.wr_dev <= 1'b1;
        end else begin
            bus.strobe_dev_oe_n <= !periph; // [RQ17]
            bus.rd_dev <= comb ? !strobing : !(strobing && outbound);
            bus.wr_dev <= comb ? outbound : !(strobing && !outbound);
        end
    end

    // =========================================================
    // Side pins
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dma_ack <= 1'b1;
            pair_mode <= 1'b0;
            flag_outputs <= '0;
            general_io_pins_out <= '0;
            general_io_pins_oe_n <= '1;
        end else begin
            dma_ack <= ctrl[CTL_ACK_HI] ? ack : !ack; // [RQ22]
            pair_mode <= ctrl[CTL_WIDE]; // [RQ10]
            for (int i = 0; i < NFLG; i++) begin // [RQ13]
                flag_outputs[i] <= flags8[cfg[CFG_ROUTE][i*RTW +: RTW]];
            end
            general_io_pins_out <= cfg[CFG_PIO_OUT][NPIO-1:0]; // [RQ14]
            general_io_pins_oe_n <= ~cfg[CFG_PIO_DIR][NPIO-1:0]; // [RQ14]
        end
    end
endmodule
`default_nettype wire

// File: bdf_fifo_array.sv
`default_nettype none
module bdf_fifo_array
    import bdf_pkg::*;
#(
    parameter int W = 18,
    parameter int AW = 9
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic push,
    input wire logic pop,
    input wire logic mark_rd,
    input wire logic back_rd,
    input wire logic mark_wr,
    input wire logic back_wr,
    input wire logic [W-1:0] wdata,
    input wire logic [AW:0] ae_off,
    input wire logic [AW:0] af_off,
    output logic [W-1:0] head,
    output logic [3:0] flags
);
    localparam logic [AW:0] DEPTH = {1'b1, {AW{1'b0}}};
    logic [W-1:0] mem [2**AW];
    logic [AW:0] wr_ptr, rd_ptr, rd_mark, wr_mark, count;
    logic do_push, do_pop;

    assign count = wr_ptr - rd_ptr;
    assign do_push = push && count != DEPTH; // [RQ24]
    assign do_pop = pop && count != '0; // [RQ24]
    assign head = mem[rd_ptr[AW-1:0]];
    // =========================================================
    // Flags
    assign flags[FL_E] = count == '0; // [RQ12]
    assign flags[FL_AE] = count <= ae_off; // [RQ12]
    assign flags[FL_AF] = count >= DEPTH - af_off; // [RQ12]
    assign flags[FL_F] = count == DEPTH; // [RQ12]

    always_ff @(posedge ref_clk) begin
        if (do_push) begin
            mem[wr_ptr[AW-1:0]] <= wdata;
        end
    end
    // =========================================================
    // Pointers and saved pointers for block repeat
    always_ff @(posedge ref_clk) begin
        if (rst || clear) begin
            wr_ptr <= '0;
        end else if (back_wr) begin
            wr_ptr <= wr_mark; // [RQ15]
        end else if (do_push) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst || clear) begin
            rd_ptr <= '0;
        end else if (back_rd) begin
            rd_ptr <= rd_mark; // [RQ15]
        end else if (do_pop) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst || clear) begin
            rd_mark <= '0;
            wr_mark <= '0;
        end else begin
            if (mark_rd) begin
                rd_mark <= rd_ptr; // [RQ15]
            end
            if (mark_wr) begin
                wr_mark <= wr_ptr; // [RQ15]
            end
        end
    end
endmodule
`default_nettype wire

// File: bdf_host.sv
`default_nettype none
module bdf_host
    import bdf_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    bdf_if.host bus,
    input wire logic a_req,
    input wire logic a_write,
    input wire logic [1:0] a_res,
    input wire logic [DW-1:0] a_wdata,
    output logic a_done,
    output logic [DW-1:0] a_rdata,
    input wire logic b_req,
    input wire logic b_write,
    input wire logic b_combined,
    input wire logic b_release,
    input wire logic [DW-1:0] b_wdata,
    output logic b_done,
    output logic [DW-1:0] b_rdata
);
    bdf_hstate_t ast, bst;
    logic [1:0] acnt, bcnt;
    logic bwr;

    // =========================================================
    // Port A master
    always_ff @(posedge ref_clk) begin
        a_done <= 1'b0;
        if (rst) begin
            ast <= BDF_H_IDLE;
            acnt <= '0;
            a_rdata <= '0;
            bus.port_a_select_n <= 1'b1;
            bus.port_a_strobe <= 1'b1;
            bus.port_a_direction <= 1'b1;
            bus.resource_select <= '0;
            bus.a_host_data <= '0;
            bus.a_host_oe_n <= 1'b1;
        end else begin
            case (ast)
                BDF_H_IDLE: if (a_req) begin
                    ast <= BDF_H_SETUP;
                    bus.port_a_select_n <= 1'b0;
                    bus.port_a_direction <= !a_write; // [RQ4]
                    bus.resource_select <= a_res;
                    bus.a_host_data <= a_wdata;
                    bus.a_host_oe_n <= !a_write;
                end
                BDF_H_SETUP: begin
                    ast <= BDF_H_LOW;
                    acnt <= '0;
                    bus.port_a_strobe <= 1'b0;
                end
                BDF_H_LOW: if (acnt == 2'(HOST_LOW_CYC - 1)) begin
                    ast <= BDF_H_HIGH;
                    a_rdata <= bus.port_a_bus;
                    bus.port_a_strobe <= 1'b1; // [RQ2]
                end else begin
                    acnt <= acnt + 1'b1;
                end
                BDF_H_HIGH: begin
                    ast <= BDF_H_IDLE;
                    a_done <= 1'b1;
                    bus.port_a_select_n <= 1'b1;
                    bus.a_host_oe_n <= 1'b1;
                end
                default: ast <= BDF_H_IDLE;
            endcase
        end
    end

    // =========================================================
    // Port B master for processor mode
    always_ff @(posedge ref_clk) begin
        b_done <= 1'b0;
        if (rst) begin
            bst <= BDF_H_IDLE;
            bcnt <= '0;
            bwr <= 1'b0;
            b_rdata <= '0;
            bus.rd_host <= 1'b1;
            bus.wr_host <= 1'b1;
            bus.strobe_host_oe_n <= 1'b0;
            bus.b_host_data <= '0;
            bus.b_host_oe_n <= 1'b1;
        end else begin
            bus.strobe_host_oe_n <= b_release;
            case (bst)
                BDF_H_IDLE: if (b_req && !b_release) begin
                    bst <= BDF_H_SETUP;
                    bwr <= b_write;
                    bus.wr_host <= !(b_combined && b_write);
                    bus.b_host_data <= b_wdata;
                    bus.b_host_oe_n <= !b_write;
                end
                BDF_H_SETUP: begin
                    bst <= BDF_H_LOW;
                    bcnt <= '0;
                    if (b_combined || !bwr) begin
                        bus.rd_host <= 1'b0; // [RQ18] [RQ19]
                    end else begin
                        bus.wr_host <= 1'b0;
                    end
                end
                BDF_H_LOW: if (bcnt == 2'(HOST_LOW_CYC - 1)) begin
                    bst <= BDF_H_HIGH;
                    b_rdata <= bus.port_b_bus;
                    bus.rd_host <= 1'b1;
                    if (!b_combined) begin
                        bus.wr_host <= 1'b1;
                    end
                end else begin
                    bcnt <= bcnt + 1'b1;
                end
                BDF_H_HIGH: begin
                    bst <= BDF_H_IDLE;
                    b_done <= 1'b1;
                    bus.wr_host <= 1'b1;
                    bus.b_host_oe_n <= 1'b1;
                end
                default: bst <= BDF_H_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: bdf_if.sv
`default_nettype none
interface bdf_if;
    import bdf_pkg::*;
    logic port_a_select_n;
    logic port_a_strobe;
    logic port_a_direction;
    logic [1:0] resource_select;
    logic [DW-1:0] a_host_data;
    logic a_host_oe_n;
    logic [DW-1:0] a_dev_data;
    logic a_dev_oe_n;
    logic [DW-1:0] b_host_data;
    logic b_host_oe_n;
    logic [DW-1:0] b_dev_data;
    logic b_dev_oe_n;
    logic rd_host;
    logic wr_host;
    logic strobe_host_oe_n;
    logic rd_dev;
    logic wr_dev;
    logic strobe_dev_oe_n;
    logic [DW-1:0] port_a_bus;
    logic [DW-1:0] port_b_bus;
    logic port_b_read_strobe;
    logic port_b_write_strobe;
    // =========================================================
    // Wire resolution, pulled high when nobody drives
    assign port_a_bus = !a_dev_oe_n ? a_dev_data :
                        !a_host_oe_n ? a_host_data : '1;
    assign port_b_bus = !b_dev_oe_n ? b_dev_data :
                        !b_host_oe_n ? b_host_data : '1;
    assign port_b_read_strobe = !strobe_dev_oe_n ? rd_dev :
                                !strobe_host_oe_n ? rd_host : 1'b1;
    assign port_b_write_strobe = !strobe_dev_oe_n ? wr_dev :
                                 !strobe_host_oe_n ? wr_host : 1'b1;
    modport dev (
        input port_a_select_n, port_a_strobe, port_a_direction,
        input resource_select, port_a_bus, port_b_bus,
        input port_b_read_strobe, port_b_write_strobe,
        output a_dev_data, a_dev_oe_n, b_dev_data, b_dev_oe_n,
        output rd_dev, wr_dev, strobe_dev_oe_n
    );
    modport host (
        output port_a_select_n, port_a_strobe, port_a_direction,
        output resource_select, a_host_data, a_host_oe_n,
        output b_host_data, b_host_oe_n, rd_host, wr_host,
        output strobe_host_oe_n,
        input port_a_bus, port_b_bus
    );
endinterface
`default_nettype wire

// File: bdf_pkg.sv
`default_nettype none
package bdf_pkg;
    localparam int DW = 18;
    localparam int BYW = 9;
    localparam int NCFG = 8;
    localparam int CPW = 3;
    localparam int NFLG = 4;
    localparam int NPIO = 6;
    localparam int FAW = 9;
    localparam int RTW = 3;
    // =========================================================
    // Port A resources (with direction: six in all)
    localparam logic [1:0] RES_FIFO = 2'h0;
    localparam logic [1:0] RES_CMD = 2'h1;
    localparam logic [1:0] RES_CFG = 2'h2;
    // =========================================================
    // Configuration register indices
    localparam logic [CPW-1:0] CFG_CTRL = 3'h0;
    localparam logic [CPW-1:0] CFG_AB_AE = 3'h1;
    localparam logic [CPW-1:0] CFG_AB_AF = 3'h2;
    localparam logic [CPW-1:0] CFG_BA_AE = 3'h3;
    localparam logic [CPW-1:0] CFG_BA_AF = 3'h4;
    localparam logic [CPW-1:0] CFG_ROUTE = 3'h5;
    localparam logic [CPW-1:0] CFG_PIO_DIR = 3'h6;
    localparam logic [CPW-1:0] CFG_PIO_OUT = 3'h7;
    // Control register bits
    localparam int CTL_PERIPH = 0;
    localparam int CTL_COMBINED = 1;
    localparam int CTL_REQ_HI = 2;
    localparam int CTL_ACK_HI = 3;
    localparam int CTL_WIDE = 4;
    localparam int CTL_BYPASS = 5;
    localparam int CTL_OUTBOUND = 6;
    // Command and status bits
    localparam int CMD_CLR_AB = 3;
    localparam int CMD_CLR_BA = 4;
    localparam int CMD_LOAD_BYP = 17;
    localparam int STS_PIO = 8;
    localparam int STS_BYP = 14;
    // Flag order inside one array
    localparam int FL_E = 0;
    localparam int FL_AE = 1;
    localparam int FL_AF = 2;
    localparam int FL_F = 3;
    localparam logic [DW-1:0] CFG_RST [NCFG] = '{18'h00000, 18'h00008,
        18'h00008, 18'h00008, 18'h00008, 18'h00F18, 18'h00000, 18'h00000};
    localparam int HOST_LOW_CYC = 2;
    typedef enum logic [1:0] {
        BDF_P_IDLE, BDF_P_ACK, BDF_P_STROBE, BDF_P_DONE
    } bdf_pstate_t;
    typedef enum logic [1:0] {
        BDF_H_IDLE, BDF_H_SETUP, BDF_H_LOW, BDF_H_HIGH
    } bdf_hstate_t;
endpackage
`default_nettype wire

// File: test_bidirectional_dual_fifo_ports.sv
`default_nettype none
`define CHK(n, s, e) begin cmp_count++; if ((s) !== (e)) begin errors++; \
    $display("FAIL %s exp %h got %h", n, e, s); end end
module test_bidirectional_dual_fifo_ports
    import bdf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 0, rst = 1, dma_request = 0, ext_clk = 0;
    logic reread_n = 1, rewrite_n = 1, load_reread = 0, load_rewrite = 0;
    logic [NPIO-1:0] general_io_pins_in = 6'h2A;
    logic [NPIO-1:0] general_io_pins_out, general_io_pins_oe_n;
    logic [NFLG-1:0] flag_outputs;
    logic dma_ack, pair_mode, a_done, b_done, b_combined = 0, b_release = 0;
    logic a_req = 0, a_write = 0, b_req = 0, b_write = 0;
    logic [1:0] a_res = 0;
    logic [DW-1:0] a_wdata = 0, b_wdata = 0, a_rdata, b_rdata, q;
    int errors = 0, cmp_count = 0;
    bdf_if bi();
    bdf_device u_bdf_device(.ref_clk, .rst, .bus(bi.dev), .dma_request,
        .ext_clk, .reread_n, .rewrite_n, .load_reread, .load_rewrite,
        .general_io_pins_in, .general_io_pins_out, .general_io_pins_oe_n,
        .flag_outputs, .dma_ack, .pair_mode);
    bdf_host u_bdf_host(.ref_clk, .rst, .bus(bi.host), .a_req, .a_write,
        .a_res, .a_wdata, .a_done, .a_rdata, .b_req, .b_write, .b_combined,
        .b_release, .b_wdata, .b_done, .b_rdata);
    bdf_checker u_bdf_checker(.ref_clk, .rst,
        .port_a_select_n(bi.port_a_select_n), .port_a_strobe(bi.port_a_strobe),
        .port_a_direction(bi.port_a_direction), .a_dev_oe_n(bi.a_dev_oe_n),
        .b_dev_oe_n(bi.b_dev_oe_n), .strobe_host_oe_n(bi.strobe_host_oe_n),
        .strobe_dev_oe_n(bi.strobe_dev_oe_n),
        .port_b_read_strobe(bi.port_b_read_strobe),
        .port_b_write_strobe(bi.port_b_write_strobe));
    initial forever #20 ref_clk = ~ref_clk;
    // One host access on port A (b=0) or port B (b=1), result in q
    task automatic op(bit b, bit w, logic [1:0] r, logic [DW-1:0] d);
        @(posedge ref_clk);
        if (b) {b_req, b_write, b_wdata} <= {1'b1, w, d};
        else {a_req, a_write, a_res, a_wdata} <= {1'b1, w, r, d};
        @(posedge ref_clk);
        {a_req, b_req} <= 2'b00;
        for (int i = 0; i < 20 && (b ? b_done : a_done) !== 1'b1; i++)
            @(negedge ref_clk);
        q = b ? b_rdata : a_rdata;
    endtask
    task automatic cfg(logic [DW-1:0] p, logic [DW-1:0] v);
        op(0, 1, RES_CMD, p);
        op(0, 1, RES_CFG, v);
    endtask
    task automatic t_reset();
        op(0, 0, RES_CMD, '0);
        `CHK("status", q, 18'h02A33)
        `CHK("flags", flag_outputs, 4'h5)
        `CHK("pio_oe", general_io_pins_oe_n, 6'h3F)
        `CHK("pair", pair_mode, 1'b0)
        `CHK("ack", dma_ack, 1'b1)
        $display("end reset");
    endtask
    task automatic t_ab();
        for (int k = 0; k < 3; k++) op(0, 1, RES_FIFO, 18'h3A5A0 + 18'(k));
        `CHK("ab_empty", flag_outputs[0], 1'b0)
        for (int k = 0; k < 3; k++) begin
            op(1, 0, 0, '0);
            `CHK("b_read", q, 18'h3A5A0 + 18'(k))
        end
        `CHK("drained", flag_outputs, 4'h5)
        $display("end a_to_b");
    endtask
    task automatic t_ba();
        cfg(18'(CFG_CTRL), 18'h00002);
        op(0, 0, RES_CFG, '0);
        `CHK("ctrl", q, 18'h00002)
        b_combined <= 1'b1;
        op(1, 1, 0, 18'h1B00D);
        op(0, 0, RES_FIFO, '0);
        `CHK("a_read", q, 18'h1B00D)
        op(0, 0, RES_FIFO, '0);
        op(1, 1, 0, 18'h00777);
        op(0, 0, RES_FIFO, '0);
        `CHK("after_empty", q, 18'h00777)
        $display("end b_to_a");
    endtask
    task automatic t_pio();
        general_io_pins_in <= 6'h15;
        dma_request <= 1'b1;
        cfg(18'(CFG_PIO_DIR), 18'h0003F);
        cfg(18'(CFG_PIO_OUT), 18'h00015);
        cfg(18'(CFG_ROUTE), '0);
        @(negedge ref_clk);
        `CHK("pio_oe", general_io_pins_oe_n, 6'h00)
        `CHK("pio_out", general_io_pins_out, 6'h15)
        `CHK("route", flag_outputs, 4'hF)
        op(0, 0, RES_CMD, '0);
        `CHK("pio_in", q[13:8], 6'h15)
        $display("end pio");
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_ab();
        t_ba();
        t_pio();
        stop_test();
    end
    initial begin
        #100000;
        errors++;
        stop_test();
    end
endmodule
`default_nettype wire
